// ==== rtl/hsbm_pkg.sv ====
// constants, states and pin layout of the host-side system bus port
// assumes a 40 MHz system clock; the bus clock is divided down from it
`default_nettype none
package hsbm_pkg;

    // clock and bus timing
    localparam int CLK_NS    = 25;
    localparam int T_SC_NS   = 60;
    localparam int T_AH_NS   = 50;
    localparam int T_BCY_NS  = 100;
    localparam int SC_CYC    = (T_SC_NS + CLK_NS - 1) / CLK_NS;
    localparam int AH_CYC    = (T_AH_NS + CLK_NS - 1) / CLK_NS;
    localparam int BCLK_HALF = (T_BCY_NS / 2 + CLK_NS - 1) / CLK_NS;
    localparam int INIT_CYC  = 16;
    localparam int CNT_W     = 8;

    // bus widths
    localparam int ADR_W = 20;
    localparam int DAT_W = 16;
    localparam int INT_N = 8;

    // bit positions of the synchronised input bundle
    localparam int SY_ADR  = 0;
    localparam int SY_DAT  = 20;
    localparam int SY_BHEN = 36;
    localparam int SY_MRDC = 37;
    localparam int SY_MWTC = 38;
    localparam int SY_XACK = 39;
    localparam int SY_BUSY = 40;
    localparam int SY_CBRQ = 41;
    localparam int SY_BREQ = 42;
    localparam int SY_INT  = 43;
    localparam int SY_W    = 51;

    // master sequencer for i/o writes
    typedef enum logic [2:0] {
        M_IDLE  = 3'b000,
        M_REQ   = 3'b001,
        M_ACQ   = 3'b010,
        M_SETUP = 3'b011,
        M_CMD   = 3'b100,
        M_HOLD  = 3'b101,
        M_REL   = 3'b110
    } hsbm_mst_t;

    // memory slave answering the device
    typedef enum logic [1:0] {
        S_IDLE = 2'b00,
        S_WAIT = 2'b01,
        S_ACK  = 2'b10,
        S_END  = 2'b11
    } hsbm_slv_t;

endpackage
`default_nettype wire

// ==== rtl/hsbm_sync.sv ====
// two-flip-flop synchroniser bank for backplane inputs
// assumes each bit is a level that may change at any time
`timescale 1ns/1ps
`default_nettype none
module hsbm_sync #(
    parameter int W     = 1,
    parameter logic [W-1:0] RST_VAL = '1
) (
    // clock, reset, enable
    input  wire  logic         clk_sys,
    input  wire  logic         rst_n,
    input  wire  logic         ce,
    // levels
    input  wire  logic [W-1:0] d,
    output logic       [W-1:0] q
);
    logic [W-1:0] meta_q;

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            meta_q <= RST_VAL;
            q      <= RST_VAL;
        end else if (ce) begin
            meta_q <= d;
            q      <= meta_q;
        end
    end
endmodule
`default_nettype wire

// ==== rtl/hsbm_host.sv ====
// host end of the system bus: bus clock, arbitration, i/o write master,
// memory slave for device transfers, interrupt and initialize lines
// assumes open-drain or two-way pins are resolved outside from the enables
//
// Functional notes
// - twenty address lines, top line most significant
// - active lowest address line selects even lane
// - low byte-high-enable gates odd lane
// - sixteen data lines, even low, odd high
// - device priority-out feeds next lower master
// - holder keeps busy; nobody else takes bus
// - eight active-low interrupts, line zero highest
// - i/o write: port address, port takes data
// - memory read: slave places location contents
// - memory write: data stored into location
// - slave acknowledges once transfer complete
`timescale 1ns/1ps
`default_nettype none
module hsbm_host
    import hsbm_pkg::*;
#(
    parameter int               MEM_WORDS = 16,
    parameter logic [ADR_W-1:0] MEM_BASE  = 20'h0_0000
) (
    // clock, reset, enable
    input  wire  logic             clk_sys,
    input  wire  logic             nrst,
    input  wire  logic             ce,
    // user i/o write request
    input  wire  logic             io_req,
    input  wire  logic [ADR_W-1:0] io_addr,
    input  wire  logic [DAT_W-1:0] io_data,
    input  wire  logic             io_bhe,
    output logic                   io_busy,
    output logic                   io_done,
    // user access to the local memory
    input  wire  logic             mem_we,
    input  wire  logic [7:0]       mem_addr,
    input  wire  logic [DAT_W-1:0] mem_wdata,
    output logic       [DAT_W-1:0] mem_rdata,
    // user initialize and status
    input  wire  logic             init_req,
    output logic       [INT_N-1:0] irq_active,
    output logic       [2:0]       irq_top,
    output logic                   irq_any,
    output logic                   dev_req,
    // bus clock and arbitration
    output logic                   bclk_n,
    output logic                   bprn_n,
    input  wire  logic             busy_n_i,
    output logic                   busy_n_o,
    output logic                   busy_n_oe,
    input  wire  logic             cbrq_n_i,
    input  wire  logic             breq_n_i,
    // address, lanes, data
    input  wire  logic [ADR_W-1:0] adr_n_i,
    output logic       [ADR_W-1:0] adr_n_o,
    output logic                   adr_n_oe,
    input  wire  logic             bhen_n_i,
    output logic                   bhen_n_o,
    input  wire  logic [DAT_W-1:0] dat_n_i,
    output logic       [DAT_W-1:0] dat_n_o,
    output logic                   dat_n_oe,
    // commands and acknowledge
    output logic                   iowc_n,
    input  wire  logic             mrdc_n_i,
    input  wire  logic             mwtc_n_i,
    input  wire  logic             xack_n_i,
    output logic                   xack_n_o,
    output logic                   xack_n_oe,
    // system lines
    output logic                   init_n,
    input  wire  logic [INT_N-1:0] int_n_i
);
    localparam int MEM_AW = (MEM_WORDS > 1) ? $clog2(MEM_WORDS) : 1;
    localparam logic [ADR_W-1:0] MEM_BYTES = ADR_W'(2 * MEM_WORDS);
    localparam logic [CNT_W-1:0] SC_CNT    = CNT_W'(SC_CYC - 1);
    localparam logic [CNT_W-1:0] AH_CNT    = CNT_W'(AH_CYC - 1);
    localparam logic [CNT_W-1:0] INIT_CNT  = CNT_W'(INIT_CYC);
    localparam logic [3:0]       HALF_CNT  = 4'(BCLK_HALF - 1);

    typedef struct packed {
        hsbm_mst_t                       mst;
        hsbm_slv_t                       slv;
        logic [3:0]                      bdiv;
        logic                            bclk;
        logic [CNT_W-1:0]                tcnt;
        logic [CNT_W-1:0]                init_cnt;
        logic                            bprn_n;
        logic                            busy_oe;
        logic [ADR_W-1:0]                adr_o;
        logic                            adr_oe;
        logic                            bhen_o;
        logic [DAT_W-1:0]                dat_o;
        logic                            dat_oe;
        logic                            iowc_n;
        logic                            xack_oe;
        logic                            init_n;
        logic                            io_busy;
        logic                            io_done;
        logic [ADR_W-1:0]                io_addr;
        logic [DAT_W-1:0]                io_data;
        logic                            io_bhe;
        logic                            rd_cmd;
        logic [MEM_AW-1:0]               idx;
        logic                            lane_even;
        logic                            lane_odd;
        logic [DAT_W-1:0]                mem_rdata;
        logic [INT_N-1:0]                irq;
        logic [2:0]                      irq_top;
        logic                            irq_any;
        logic                            dev_req;
        logic [MEM_WORDS-1:0][DAT_W-1:0] mem;
    } hsbm_state_t;

    // logical address <-> pin levels: lines 19..1 inverted, line 0 is the even enable
    function automatic logic [ADR_W-1:0] adr_swap(input logic [ADR_W-1:0] a);
        adr_swap = {~a[ADR_W-1:1], a[0]};
    endfunction

    logic [1:0]       rst_q;
    logic             rst_n;
    logic [SY_W-1:0]  sy;
    hsbm_state_t      q;
    hsbm_state_t      d;

    // reset release
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            rst_q <= 2'b00;
        end else begin
            rst_q <= {rst_q[0], 1'b1};
        end
    end
    assign rst_n = rst_q[1];

    hsbm_sync #(
        .W       (SY_W),
        .RST_VAL ({SY_W{1'b1}})
    ) u_sync (
        .clk_sys (clk_sys),
        .rst_n   (rst_n),
        .ce      (ce),
        .d       ({int_n_i, breq_n_i, cbrq_n_i, busy_n_i, xack_n_i,
                   mwtc_n_i, mrdc_n_i, bhen_n_i, dat_n_i, adr_n_i}),
        .q       (sy)
    );

    logic [ADR_W-1:0] s_adr;
    logic [DAT_W-1:0] s_dat;
    logic [INT_N-1:0] s_int;
    logic             s_busy_n;
    logic             s_xack_n;
    logic             s_rd;
    logic             s_wr;
    assign s_adr    = adr_swap(sy[SY_ADR +: ADR_W]);
    assign s_dat    = ~sy[SY_DAT +: DAT_W];
    assign s_int    = ~sy[SY_INT +: INT_N];
    assign s_busy_n = sy[SY_BUSY];
    assign s_xack_n = sy[SY_XACK];
    assign s_rd     = ~sy[SY_MRDC];
    assign s_wr     = ~sy[SY_MWTC];

    always_comb begin
        logic             tick;
        logic [ADR_W-1:0] off;
        logic             hit;
        d         = q;
        tick      = 1'b0;
        off       = s_adr - MEM_BASE;
        hit       = off < MEM_BYTES;
        d.io_done = 1'b0;

        // bus clock divider; arbitration steps on the falling bus clock edge
        if (q.bdiv == HALF_CNT) begin
            d.bdiv = 4'h0;
            d.bclk = ~q.bclk;
            tick   = q.bclk;
        end else begin
            d.bdiv = q.bdiv + 4'h1;
        end

        // initialize pulse
        if (init_req) begin
            d.init_cnt = INIT_CNT;
        end else if (q.init_cnt != '0) begin
            d.init_cnt = q.init_cnt - 1'b1;
        end
        d.init_n = (d.init_cnt == '0);

        // interrupt lines, lowest number wins
        d.irq     = s_int;
        d.irq_any = |s_int;
        d.irq_top = 3'h0;
        for (int i = INT_N - 1; i >= 0; i--) begin
            if (s_int[i]) begin
                d.irq_top = 3'(i);
            end
        end
        d.dev_req = ~sy[SY_CBRQ] | ~sy[SY_BREQ];

        // i/o write master
        case (q.mst)
            M_IDLE: begin
                if (io_req) begin
                    d.io_addr = io_addr;
                    d.io_data = io_data;
                    d.io_bhe  = io_bhe;
                    d.io_busy = 1'b1;
                    d.mst     = M_REQ;
                end
            end
            M_REQ: begin
                if (tick) begin
                    d.bprn_n = 1'b1;
                    d.mst    = M_ACQ;
                end
            end
            M_ACQ: begin
                if (tick && s_busy_n && q.slv == S_IDLE) begin
                    d.busy_oe = 1'b1;
                    d.adr_o   = adr_swap(q.io_addr);
                    d.adr_oe  = 1'b1;
                    d.bhen_o  = ~q.io_bhe;
                    d.dat_o   = ~q.io_data;
                    d.dat_oe  = 1'b1;
                    d.tcnt    = '0;
                    d.mst     = M_SETUP;
                end
            end
            M_SETUP: begin
                if (q.tcnt == SC_CNT) begin
                    d.iowc_n = 1'b0;
                    d.mst    = M_CMD;
                end else begin
                    d.tcnt = q.tcnt + 1'b1;
                end
            end
            M_CMD: begin
                if (!s_xack_n) begin
                    d.iowc_n = 1'b1;
                    d.tcnt   = '0;
                    d.mst    = M_HOLD;
                end
            end
            M_HOLD: begin
                if (q.tcnt == AH_CNT) begin
                    d.adr_oe = 1'b0;
                    d.dat_oe = 1'b0;
                    d.bhen_o = 1'b1;
                    d.mst    = M_REL;
                end else begin
                    d.tcnt = q.tcnt + 1'b1;
                end
            end
            M_REL: begin
                if (tick) begin
                    d.busy_oe = 1'b0;
                    d.bprn_n  = 1'b0;
                    d.io_busy = 1'b0;
                    d.io_done = 1'b1;
                    d.mst     = M_IDLE;
                end
            end
            default: begin
                d.mst = M_IDLE;
            end
        endcase

        // local memory, user write first so a device write in the same cycle wins
        if (mem_we && mem_addr < 8'(MEM_WORDS)) begin
            d.mem[MEM_AW'(mem_addr)] = mem_wdata;
        end
        d.mem_rdata = (mem_addr < 8'(MEM_WORDS)) ? q.mem[MEM_AW'(mem_addr)] : '0;

        // memory slave for device transfers; the device holds until acknowledged
        case (q.slv)
            S_IDLE: begin
                if ((s_rd || s_wr) && hit && q.mst != M_SETUP && q.mst != M_CMD && q.mst != M_HOLD) begin
                    d.rd_cmd    = s_rd;
                    d.idx       = off[MEM_AW:1];
                    d.lane_even = ~sy[SY_ADR];
                    d.lane_odd  = ~sy[SY_BHEN];
                    d.slv       = S_WAIT;
                end
            end
            S_WAIT: begin
                if (q.rd_cmd) begin
                    d.dat_o  = ~q.mem[q.idx];
                    d.dat_oe = 1'b1;
                end else begin
                    if (q.lane_even) begin
                        d.mem[q.idx][7:0] = s_dat[7:0];
                    end
                    if (q.lane_odd) begin
                        d.mem[q.idx][15:8] = s_dat[15:8];
                    end
                end
                d.slv = S_ACK;
            end
            S_ACK: begin
                d.xack_oe = 1'b1;
                d.slv     = S_END;
            end
            S_END: begin
                if (!s_rd && !s_wr) begin
                    d.xack_oe = 1'b0;
                    d.dat_oe  = 1'b0;
                    d.slv     = S_IDLE;
                end
            end
            default: begin
                d.slv = S_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            q           <= '0;
            q.mst       <= M_IDLE;
            q.slv       <= S_IDLE;
            q.bclk      <= 1'b1;
            q.adr_o     <= {ADR_W{1'b1}};
            q.bhen_o    <= 1'b1;
            q.dat_o     <= {DAT_W{1'b1}};
            q.iowc_n    <= 1'b1;
            q.init_n    <= 1'b0;
            q.init_cnt  <= INIT_CNT;
        end else if (ce) begin
            q <= d;
        end
    end

    // pins and user outputs
    assign bclk_n     = q.bclk;
    assign bprn_n     = q.bprn_n;
    assign busy_n_o   = 1'b0;
    assign busy_n_oe  = q.busy_oe;
    assign adr_n_o    = q.adr_o;
    assign adr_n_oe   = q.adr_oe;
    assign bhen_n_o   = q.bhen_o;
    assign dat_n_o    = q.dat_o;
    assign dat_n_oe   = q.dat_oe;
    assign iowc_n     = q.iowc_n;
    assign xack_n_o   = 1'b0;
    assign xack_n_oe  = q.xack_oe;
    assign init_n     = q.init_n;
    assign io_busy    = q.io_busy;
    assign io_done    = q.io_done;
    assign mem_rdata  = q.mem_rdata;
    assign irq_active = q.irq;
    assign irq_top    = q.irq_top;
    assign irq_any    = q.irq_any;
    assign dev_req    = q.dev_req;
endmodule
`default_nettype wire

// ==== tb/hsbm_host_assertions.sv ====
// checker: port timing relations of the host bus port
// assumes bind onto hsbm_host with ce held high
`timescale 1ns/1ps
`default_nettype none
module hsbm_host_assertions
    import hsbm_pkg::*;
(
    // clock, reset
    input wire logic             clk_sys,
    input wire logic             nrst,
    // watched ports
    input wire logic             io_done,
    input wire logic [INT_N-1:0] irq_active,
    input wire logic [2:0]       irq_top,
    input wire logic             irq_any,
    input wire logic             bclk_n,
    input wire logic             bprn_n,
    input wire logic             busy_n_oe,
    input wire logic             adr_n_oe,
    input wire logic             dat_n_oe,
    input wire logic             iowc_n,
    input wire logic             mrdc_n_i,
    input wire logic             mwtc_n_i,
    input wire logic             xack_n_i,
    input wire logic             xack_n_oe,
    input wire logic             init_n,
    input wire logic             cbrq_n_i,
    input wire logic             breq_n_i,
    input wire logic             dev_req
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!nrst);
    a_bclk_shape: assert property ($fell(bclk_n) |=> !bclk_n ##1 bclk_n [*2] ##1 !bclk_n) else $error("bclk shape");
    a_owner_prio: assert property (busy_n_oe |-> bprn_n) else $error("bprn low while owning");
    a_cmd_owned: assert property (!iowc_n |-> busy_n_oe && adr_n_oe && dat_n_oe) else $error("cmd off bus");
    a_cmd_setup: assert property ($fell(iowc_n) |-> $past(adr_n_oe, 3) && $past(dat_n_oe, 3)) else $error("setup");
    a_cmd_ends: assert property (!iowc_n && !xack_n_i |-> ##[1:4] iowc_n) else $error("cmd kept");
    a_addr_hold: assert property ($rose(iowc_n) |-> (adr_n_oe && dat_n_oe) [*2]) else $error("hold");
    a_xack_drop: assert property (xack_n_oe && mrdc_n_i && mwtc_n_i |-> ##[1:4] !xack_n_oe) else $error("xack");
    a_read_data: assert property (xack_n_oe && !mrdc_n_i |-> dat_n_oe) else $error("read data off");
    a_irq_prio: assert property ((irq_any == (irq_active != 8'h00)) && (!irq_any || (irq_active[irq_top]
        && (irq_active & ((8'h01 << irq_top) - 8'h01)) == 8'h00))) else $error("irq priority");
    a_dev_req: assert property (dev_req == $past(!cbrq_n_i || !breq_n_i, 3)) else $error("dev_req lag");
    a_init_len: assert property ($fell(init_n) |=> !init_n [*8]) else $error("init short");
    c_io_done: cover property (io_done);
    c_dev_read: cover property (xack_n_oe && !mrdc_n_i);
    c_dev_write: cover property (xack_n_oe && !mwtc_n_i);
    c_irq: cover property (irq_any);
endmodule
bind hsbm_host hsbm_host_assertions u_hsbm_host_assertions (.clk_sys(clk_sys), .nrst(nrst), .io_done(io_done),
    .irq_active(irq_active), .irq_top(irq_top), .irq_any(irq_any), .bclk_n(bclk_n), .bprn_n(bprn_n),
    .busy_n_oe(busy_n_oe), .adr_n_oe(adr_n_oe), .dat_n_oe(dat_n_oe), .iowc_n(iowc_n), .mrdc_n_i(mrdc_n_i),
    .mwtc_n_i(mwtc_n_i), .xack_n_i(xack_n_i), .xack_n_oe(xack_n_oe), .init_n(init_n),
    .cbrq_n_i(cbrq_n_i), .breq_n_i(breq_n_i), .dev_req(dev_req));
`default_nettype wire

// ==== tb/hsbm_dev_model.sv ====
// device on the backplane: i/o write slave and memory bus master
// assumes the bench resolves the shared lines, pull-ups when released
`timescale 1ns/1ps
`default_nettype none
module hsbm_dev_model (
    // bus clock and system lines
    input  wire logic        bclk_n,
    input  wire logic        init_n,
    input  wire logic        bprn_n,
    input  wire logic        slow,
    // shared lines
    input  wire logic        busy_ln,
    input  wire logic        xack_ln,
    input  wire logic        iowc_n,
    input  wire logic [19:0] adr_ln,
    input  wire logic        bhen_ln,
    input  wire logic [15:0] dat_ln,
    // device drive
    output logic             busy_oe,
    output logic             xack_oe,
    output logic             cbrq_n,
    output logic             breq_n,
    output logic [19:0]      adr_o,
    output logic             bhen_o,
    output logic             adr_oe,
    output logic [15:0]      dat_o,
    output logic             dat_oe,
    output logic             mrdc_n,
    output logic             mwtc_n,
    // observed transfers
    output logic             obs_v,
    output logic [36:0]      obs
);
    logic      want;
    wire logic bpro_n = bprn_n | want;
    task automatic idle();
        {busy_oe, xack_oe, adr_oe, dat_oe, obs_v, want} = '0;
        {cbrq_n, breq_n, mrdc_n, mwtc_n, bhen_o} = '1;
        adr_o = '1;
        dat_o = '1;
        obs = '0;
    endtask
    initial idle();
    always @(negedge init_n) idle();
    // i/o port: take data, acknowledge, hold until command ends
    always @(negedge iowc_n) begin
        @(negedge bclk_n);
        if (slow) repeat (3) @(negedge bclk_n);
        #1;
        obs = {bhen_ln, ~adr_ln[19:1], adr_ln[0], ~dat_ln};
        obs_v = 1'b1;
        xack_oe = 1'b1;
        wait (iowc_n);
        #1;
        {xack_oe, obs_v} = 2'b00;
    end
    task automatic mem_op(input logic we, input logic [19:0] a, input logic [15:0] d, input logic bhe,
                          output logic acked);
        int n;
        n = 0;
        @(negedge bclk_n) #1;
        want = 1'b1;
        {cbrq_n, breq_n} = 2'b00;
        while ((bprn_n || !busy_ln) && n < 200) begin
            @(negedge bclk_n) #1;
            n++;
        end
        busy_oe = 1'b1;
        cbrq_n = 1'b1;
        adr_o = {~a[19:1], a[0]};
        bhen_o = ~bhe;
        dat_o = ~d;
        {adr_oe, dat_oe} = {1'b1, we};
        @(negedge bclk_n) #1;
        {mrdc_n, mwtc_n} = we ? 2'b10 : 2'b01;
        n = 0;
        while (xack_ln && n < 40) begin
            @(negedge bclk_n) #1;
            n++;
        end
        acked = !xack_ln;
        obs = {1'b0, a, ~dat_ln};
        obs_v = acked && !we;
        {mrdc_n, mwtc_n} = 2'b11;
        @(negedge bclk_n) #1;
        {adr_oe, dat_oe, obs_v, busy_oe, want} = '0;
        breq_n = 1'b1;
    endtask
endmodule
`default_nettype wire

// ==== tb/ieee796_host_bus_master_port_test.sv ====
// bench: host port against the device model, scoreboard on bus transfers
// assumes the checker is bound onto hsbm_host
`timescale 1ns/1ps
`default_nettype none
module ieee796_host_bus_master_port_test
    import hsbm_pkg::*;
;
    localparam int               MEM_WORDS = 16;
    localparam logic [ADR_W-1:0] MEM_BASE  = 20'h0_0000;
    logic             clk_sys = 0, nrst = 0, ce = 1, io_req = 0, io_bhe = 0, mem_we = 0, init_req = 0, slow = 0;
    logic [ADR_W-1:0] io_addr = '0, d_adr;
    logic [DAT_W-1:0] io_data = '0, mem_wdata = '0, mem_rdata, dat_n_o, d_dat;
    logic [7:0]       mem_addr = '0, int_n = 8'hff, irq_active;
    logic [2:0]       irq_top;
    logic [19:0]      adr_n_o;
    logic [36:0]      obs;
    logic [36:0]      exp_q[$];
    logic [15:0]      exp_mem[MEM_WORDS];
    logic [31:0]      rnd = 32'h0000_7acf;
    logic             io_busy, io_done, irq_any, bclk_n, bprn_n, busy_n_o, busy_n_oe, adr_n_oe, bhen_n_o, dat_n_oe;
    logic             iowc_n, xack_n_o, xack_n_oe, init_n, d_busy, d_xack, cbrq_n, breq_n, d_bhen, d_adr_oe;
    logic             d_dat_oe, mrdc_n, mwtc_n, obs_v;
    int               n_fail = 0, checks_done = 0;
    wire logic        busy_ln = !((busy_n_oe && !busy_n_o) || d_busy);
    wire logic        xack_ln = !((xack_n_oe && !xack_n_o) || d_xack);
    wire logic [19:0] adr_ln  = adr_n_oe ? adr_n_o : d_adr_oe ? d_adr : '1;
    wire logic        bhen_ln = adr_n_oe ? bhen_n_o : d_adr_oe ? d_bhen : 1'b1;
    wire logic [15:0] dat_ln  = dat_n_oe ? dat_n_o : d_dat_oe ? d_dat : '1;
    hsbm_host #(.MEM_WORDS(MEM_WORDS), .MEM_BASE(MEM_BASE)) u_hsbm_host (.clk_sys(clk_sys), .nrst(nrst), .ce(ce),
        .io_req(io_req), .io_addr(io_addr), .io_data(io_data), .io_bhe(io_bhe), .io_busy(io_busy), .io_done(io_done),
        .mem_we(mem_we), .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata), .init_req(init_req),
        .irq_active(irq_active), .irq_top(irq_top), .irq_any(irq_any), .dev_req(), .bclk_n(bclk_n), .bprn_n(bprn_n),
        .busy_n_i(busy_ln), .busy_n_o(busy_n_o), .busy_n_oe(busy_n_oe), .cbrq_n_i(cbrq_n), .breq_n_i(breq_n),
        .adr_n_i(adr_ln), .adr_n_o(adr_n_o), .adr_n_oe(adr_n_oe), .bhen_n_i(bhen_ln), .bhen_n_o(bhen_n_o),
        .dat_n_i(dat_ln), .dat_n_o(dat_n_o), .dat_n_oe(dat_n_oe), .iowc_n(iowc_n), .mrdc_n_i(mrdc_n),
        .mwtc_n_i(mwtc_n), .xack_n_i(xack_ln), .xack_n_o(xack_n_o), .xack_n_oe(xack_n_oe), .init_n(init_n),
        .int_n_i(int_n));
    hsbm_dev_model u_hsbm_dev_model (.bclk_n(bclk_n), .init_n(init_n), .bprn_n(bprn_n), .slow(slow),
        .busy_ln(busy_ln), .xack_ln(xack_ln), .iowc_n(iowc_n), .adr_ln(adr_ln), .bhen_ln(bhen_ln), .dat_ln(dat_ln),
        .busy_oe(d_busy), .xack_oe(d_xack), .cbrq_n(cbrq_n), .breq_n(breq_n), .adr_o(d_adr), .bhen_o(d_bhen),
        .adr_oe(d_adr_oe), .dat_o(d_dat), .dat_oe(d_dat_oe), .mrdc_n(mrdc_n), .mwtc_n(mwtc_n), .obs_v(obs_v),
        .obs(obs));
    always #12.5 clk_sys = ~clk_sys;
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic give_verdict();
        if (n_fail == 0 && checks_done > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    task automatic chk(input logic [36:0] got, input logic [36:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_fail++;
            $display("mismatch at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask
    task automatic wait_for(output int n);
        n = 0;
        while (init_n !== 1'b1 && n < 3000) begin
            @(negedge clk_sys);
            n++;
        end
        if (n == 3000) begin
            n_fail++;
            give_verdict();
        end
    endtask
    task automatic io_write(input logic [19:0] a, input logic [15:0] d, input logic b);
        int n;
        exp_q.push_back({~b, a, d});
        @(posedge clk_sys);
        io_req <= 1'b1;
        io_addr <= a;
        io_data <= d;
        io_bhe <= b;
        @(posedge clk_sys);
        io_req <= 1'b0;
        n = 0;
        while (io_done !== 1'b1 && n < 3000) begin
            @(negedge clk_sys);
            n++;
        end
        if (n == 3000) begin
            n_fail++;
            give_verdict();
        end
    endtask
    task automatic dev_op(input logic we, input logic [19:0] a, input logic [15:0] d, input logic b, input logic ok);
        logic ack;
        if (ok && !we) exp_q.push_back({1'b0, a, d});
        u_hsbm_dev_model.mem_op(we, a, d, b, ack);
        chk(ack, ok);
    endtask
    always @(posedge obs_v) begin
        if (exp_q.size() == 0) chk(obs_v, 1'b0);
        else chk(obs, exp_q.pop_front());
    end
    initial begin
        repeat (90000) @(posedge clk_sys);
        n_fail++;
        give_verdict();
    end
    initial begin
        int i, k, n;
        logic [7:0] act;
        logic [2:0] top;
        repeat (3) @(posedge clk_sys);
        nrst <= 1'b1;
        chk(init_n, 1'b0);
        while (init_n !== 1'b1 && n < 200) begin
            @(negedge clk_sys);
            n++;
        end
        chk(n >= INIT_CYC && n < 200, 1'b1);
        for (i = 0; i < 6; i++) begin
            rnd = lfsr(lfsr(rnd));
            slow <= i[0];
            io_write(rnd[19:0], rnd[31:16] ^ rnd[15:0], rnd[5]);
        end
        for (i = 0; i < MEM_WORDS; i++) begin
            rnd = lfsr(rnd);
            exp_mem[i] = rnd[15:0];
            @(posedge clk_sys);
            mem_we <= 1'b1;
            mem_addr <= i[7:0];
            mem_wdata <= rnd[15:0];
        end
        @(posedge clk_sys);
        mem_we <= 1'b0;
        dev_op(0, MEM_BASE + 20'(2 * MEM_WORDS - 1), exp_mem[MEM_WORDS-1], 1, 1);
        dev_op(0, MEM_BASE, exp_mem[0], 1, 1);
        dev_op(1, MEM_BASE + 20'h0_0006, 16'h1234, 1, 1);
        dev_op(1, MEM_BASE + 20'h0_0006, 16'habcd, 0, 1);
        dev_op(1, MEM_BASE + 20'h0_0007, 16'h5566, 1, 1);
        exp_mem[3] = 16'h55cd;
        @(posedge clk_sys);
        mem_addr <= 8'h03;
        repeat (2) @(posedge clk_sys);
        @(negedge clk_sys);
        chk(mem_rdata, exp_mem[3]);
        dev_op(0, MEM_BASE + 20'h0_0007, exp_mem[3], 1, 1);
        dev_op(0, MEM_BASE + 20'(2 * MEM_WORDS), 16'h0000, 1, 0);
        fork
            dev_op(0, MEM_BASE + 20'h0_0002, exp_mem[1], 1, 1);
            begin
                repeat (16) @(posedge clk_sys);
                io_write(20'h0_0f0e, 16'h5aa5, 0);
            end
        join
        for (i = 0; i < 13; i++) begin
            rnd = lfsr(rnd);
            @(posedge clk_sys);
            int_n <= (i < 8) ? ~(8'h01 << i) : (i == 12) ? 8'hff : rnd[7:0];
            repeat (5) @(posedge clk_sys);
            @(negedge clk_sys);
            act = ~int_n;
            top = 3'd0;
            for (k = 7; k >= 0; k--) if (act[k]) top = k[2:0];
            chk({irq_any, irq_top, irq_active}, {|act, top, act});
        end
        @(posedge clk_sys);
        init_req <= 1'b1;
        @(posedge clk_sys);
        init_req <= 1'b0;
        repeat (3) @(negedge clk_sys);
        chk(init_n, 1'b0);
        wait_for(n);
        chk(exp_q.size(), 0);
        give_verdict();
    end
endmodule
`default_nettype wire
